// [src/regbank_pkg.sv]
package regbank_pkg;
    // Frame layout
    localparam int FRAME_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int RW_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int NREG = 26;
    localparam int IDX_W = 5;

    // Register addresses, 7-bit word addresses
    localparam logic [6:0] A_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] A_BUS_ONE = 7'h03;
    localparam logic [6:0] A_BUS_TWO = 7'h04;
    localparam logic [6:0] A_WAKE_ONE = 7'h05;
    localparam logic [6:0] A_WAKE_TWO = 7'h06;
    localparam logic [6:0] A_WAKE_PULL = 7'h08;
    localparam logic [6:0] A_WAKE_FILT = 7'h09;
    localparam logic [6:0] A_CYC_TIMER = 7'h0c;
    localparam logic [6:0] A_SW_SHDN = 7'h10;
    localparam logic [6:0] A_HS_ONE = 7'h14;
    localparam logic [6:0] A_HS_TWO = 7'h15;
    localparam logic [6:0] A_GPIN = 7'h17;
    localparam logic [6:0] A_DUTY_ONE = 7'h18;
    localparam logic [6:0] A_DUTY_TWO = 7'h19;
    localparam logic [6:0] A_FREQ = 7'h1c;
    localparam logic [6:0] A_SCRATCH = 7'h1e;
    localparam logic [6:0] A_SUP_TWO = 7'h40;
    localparam logic [6:0] A_SUP_ONE = 7'h41;
    localparam logic [6:0] A_THERM = 7'h42;
    localparam logic [6:0] A_DEV = 7'h43;
    localparam logic [6:0] A_BUSF = 7'h44;
    localparam logic [6:0] A_WAKEF_ONE = 7'h46;
    localparam logic [6:0] A_WAKEF_TWO = 7'h47;
    localparam logic [6:0] A_HS_OVL = 7'h4c;
    localparam logic [6:0] A_HS_OPEN = 7'h4d;
    localparam logic [6:0] A_FAM_PROD = 7'h7e;

    // Index of the first flag register and of the id register
    localparam int FIRST_FLAG = 16;
    localparam int ID_IDX = 25;
    localparam int MODE_IDX = 0;

    // Operating mode field of mode_supply_control
    localparam int MODE_LSB = 6;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RST = 2'h3;
    // Supply enable field forced off on restart
    localparam int VCC2_LSB = 3;

    // Power-on values, restart values and restart keep masks
    localparam logic [7:0] MODE_POR = 8'h00;
    localparam logic [7:0] MODE_RST_VAL = 8'h00;
    localparam logic [7:0] MODE_RST_KEEP = 8'h23;
    localparam logic [7:0] CTRL_POR = 8'h00;
    localparam logic [7:0] CTRL_RST_KEEP = 8'hff;

    // Writable bit masks; reserved bits are outside the mask
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] WMASK_WAKE_ONE = 8'hc4;
    localparam logic [7:0] WMASK_WAKE_TWO = 8'ha7;
    localparam logic [7:0] WMASK_WAKE_PULL = 8'h3f;
    localparam logic [7:0] WMASK_WAKE_FILT = 8'h3f;
    localparam logic [7:0] WMASK_TIMER = 8'h77;
    localparam logic [7:0] WMASK_SW_SHDN = 8'h30;
    localparam logic [7:0] WMASK_HS = 8'h77;
    localparam logic [7:0] WMASK_FREQ = 8'h05;
    localparam logic [7:0] WMASK_BUS_ONE = 8'h00;
    localparam logic [7:0] WMASK_BUS_TWO = 8'h00;
    // Hardware-modifiable bits of mode_supply_control
    localparam logic [7:0] HMASK_MODE = 8'hfc;
endpackage

// [src/frame_decode.sv]
`timescale 1ns/1ps
module frame_decode (
    // Received frame
    input wire logic [15:0] frame,
    // Decoded fields
    output logic is_write,
    output logic [6:0] addr,
    output logic [7:0] data
);
    // frame field split
    // Address and mode in the low byte, data byte in the high byte
    always_comb begin
        is_write = frame[regbank_pkg::RW_BIT];
        addr = frame[regbank_pkg::ADDR_W-1:0];
        data = frame[regbank_pkg::DATA_LSB +: regbank_pkg::DATA_W];
    end
endmodule

// [src/reg_bank.sv]
`timescale 1ns/1ps
module reg_bank #(
    parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identity value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Frame strobe and received frame
    input wire logic frame_valid,
    input wire logic [15:0] frame_in,
    // System events
    input wire logic restart,
    input wire logic [7:0] hw_mode_val,
    input wire logic hw_mode_we,
    input wire logic [7:0] flag_set [9],
    // Answer to the host
    output logic [15:0] frame_out,
    output logic frame_out_valid,
    // Control outputs
    output logic [1:0] op_mode,
    output logic soft_reset_req,
    output logic [7:0] ctrl_regs [16]
);
    typedef struct packed {
        logic [25:0][7:0] regs;
        logic [15:0] resp;
        logic resp_v;
        logic srst;
    } state_t;

    state_t st_ff, nxt_st;
    logic is_write;
    logic [6:0] addr;
    logic [7:0] wdata;

    frame_decode u_dec (
        .frame(frame_in),
        .is_write(is_write),
        .addr(addr),
        .data(wdata)
    );

    // Address to register index; out-of-map gives hit low
    function automatic logic [5:0] lookup(input logic [6:0] a);
        case (a)
            regbank_pkg::A_MODE_SUPPLY: lookup = {1'b1, 5'd0};
            regbank_pkg::A_BUS_ONE: lookup = {1'b1, 5'd1};
            regbank_pkg::A_BUS_TWO: lookup = {1'b1, 5'd2};
            regbank_pkg::A_WAKE_ONE: lookup = {1'b1, 5'd3};
            regbank_pkg::A_WAKE_TWO: lookup = {1'b1, 5'd4};
            regbank_pkg::A_WAKE_PULL: lookup = {1'b1, 5'd5};
            regbank_pkg::A_WAKE_FILT: lookup = {1'b1, 5'd6};
            regbank_pkg::A_CYC_TIMER: lookup = {1'b1, 5'd7};
            regbank_pkg::A_SW_SHDN: lookup = {1'b1, 5'd8};
            regbank_pkg::A_HS_ONE: lookup = {1'b1, 5'd9};
            regbank_pkg::A_HS_TWO: lookup = {1'b1, 5'd10};
            regbank_pkg::A_GPIN: lookup = {1'b1, 5'd11};
            regbank_pkg::A_DUTY_ONE: lookup = {1'b1, 5'd12};
            regbank_pkg::A_DUTY_TWO: lookup = {1'b1, 5'd13};
            regbank_pkg::A_FREQ: lookup = {1'b1, 5'd14};
            regbank_pkg::A_SCRATCH: lookup = {1'b1, 5'd15};
            regbank_pkg::A_SUP_TWO: lookup = {1'b1, 5'd16};
            regbank_pkg::A_SUP_ONE: lookup = {1'b1, 5'd17};
            regbank_pkg::A_THERM: lookup = {1'b1, 5'd18};
            regbank_pkg::A_DEV: lookup = {1'b1, 5'd19};
            regbank_pkg::A_BUSF: lookup = {1'b1, 5'd20};
            regbank_pkg::A_WAKEF_ONE: lookup = {1'b1, 5'd21};
            regbank_pkg::A_WAKEF_TWO: lookup = {1'b1, 5'd22};
            regbank_pkg::A_HS_OVL: lookup = {1'b1, 5'd23};
            regbank_pkg::A_HS_OPEN: lookup = {1'b1, 5'd24};
            regbank_pkg::A_FAM_PROD: lookup = {1'b1, 5'd25};
            default: lookup = 6'h00;
        endcase
    endfunction

    // Host-writable bits per control register
    function automatic logic [7:0] wmask(input logic [4:0] i);
        case (i)
            5'd1: wmask = regbank_pkg::WMASK_BUS_ONE;
            5'd2: wmask = regbank_pkg::WMASK_BUS_TWO;
            5'd3: wmask = regbank_pkg::WMASK_WAKE_ONE;
            5'd4: wmask = regbank_pkg::WMASK_WAKE_TWO;
            5'd5: wmask = regbank_pkg::WMASK_WAKE_PULL;
            5'd6: wmask = regbank_pkg::WMASK_WAKE_FILT;
            5'd7: wmask = regbank_pkg::WMASK_TIMER;
            5'd8: wmask = regbank_pkg::WMASK_SW_SHDN;
            5'd9: wmask = regbank_pkg::WMASK_HS;
            5'd10: wmask = regbank_pkg::WMASK_HS;
            5'd14: wmask = regbank_pkg::WMASK_FREQ;
            default: wmask = regbank_pkg::WMASK_FULL;
        endcase
    endfunction

    // Next-state logic for the whole bank
    always_comb begin
        logic [5:0] hit;
        logic [4:0] idx;
        logic [7:0] cur;
        logic [7:0] m;
        nxt_st = st_ff;
        hit = lookup(addr);
        idx = hit[4:0];
        cur = st_ff.regs[idx];
        m = wmask(idx);
        nxt_st.resp_v = 1'b0;
        nxt_st.srst = 1'b0;
        if (hw_mode_we) begin
            nxt_st.regs[regbank_pkg::MODE_IDX] =
                (st_ff.regs[regbank_pkg::MODE_IDX] & ~regbank_pkg::HMASK_MODE)
                | (hw_mode_val & regbank_pkg::HMASK_MODE);
        end
        if (frame_valid) begin
            nxt_st.resp = {hit[5] ? cur : 8'h00, frame_in[7:0]};
            nxt_st.resp_v = 1'b1;
            if (hit[5] && idx < 5'(regbank_pkg::FIRST_FLAG) && is_write) begin
                nxt_st.regs[idx] = (cur & ~m) | (wdata & m);
                if (idx == 5'(regbank_pkg::MODE_IDX) &&
                    wdata[regbank_pkg::MODE_LSB +: 2] ==
                    regbank_pkg::MODE_SOFT_RST) begin
                    nxt_st.srst = 1'b1;
                end
            end
            if (hit[5] && idx >= 5'(regbank_pkg::FIRST_FLAG) &&
                idx != 5'(regbank_pkg::ID_IDX)) begin
                nxt_st.regs[idx] = 8'h00;
            end
        end
        // Flags set by hardware win over a clearing read
        for (int k = 0; k < 9; k++) begin
            nxt_st.regs[regbank_pkg::FIRST_FLAG + k] =
                nxt_st.regs[regbank_pkg::FIRST_FLAG + k] | flag_set[k];
        end
        if (restart) begin
            nxt_st.regs[regbank_pkg::MODE_IDX] =
                (st_ff.regs[regbank_pkg::MODE_IDX]
                 & regbank_pkg::MODE_RST_KEEP)
                | (regbank_pkg::MODE_RST_VAL & ~regbank_pkg::MODE_RST_KEEP);
        end
        nxt_st.regs[regbank_pkg::ID_IDX] = ID_VALUE;
    end

    // reset and soft reset load defaults
    always_ff @(posedge clk) begin
        if (reset || st_ff.srst) begin
            for (int k = 0; k < regbank_pkg::NREG; k++) begin
                st_ff.regs[k] <= regbank_pkg::CTRL_POR;
            end
            st_ff.regs[regbank_pkg::ID_IDX] <= ID_VALUE;
            st_ff.resp <= 16'h0000;
            st_ff.resp_v <= 1'b0;
            st_ff.srst <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        frame_out = st_ff.resp;
        frame_out_valid = st_ff.resp_v;
        op_mode = st_ff.regs[regbank_pkg::MODE_IDX][regbank_pkg::MODE_LSB +: 2];
        soft_reset_req = st_ff.srst;
        for (int k = 0; k < 16; k++) begin
            ctrl_regs[k] = st_ff.regs[k];
        end
    end
endmodule

// [testbench/reg_bank_sva.sv]
`timescale 1ns/1ps
// Port-level checks of the register bank
module reg_bank_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Frame side and system events
    input wire logic frame_valid,
    input wire logic [15:0] frame_in,
    input wire logic restart,
    input wire logic hw_mode_we,
    // Answer and controls
    input wire logic [15:0] frame_out,
    input wire logic frame_out_valid,
    input wire logic [1:0] op_mode,
    input wire logic soft_reset_req,
    input wire logic [7:0] ctrl_regs [16]
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Frame taken with no competing system event
    sequence s_take;
        frame_valid && !restart && !hw_mode_we && !soft_reset_req;
    endsequence
    sequence s_mode_wr;
        s_take ##0 (frame_in[7] &&
            frame_in[6:0] == regbank_pkg::A_MODE_SUPPLY);
    endsequence

    AST_ANSWER: assert property (frame_valid |=> frame_out_valid)
        else $error("no answer one cycle after a frame");
    AST_IDLE: assert property (!frame_valid |=> !frame_out_valid)
        else $error("answer without a frame");
    AST_ECHO: assert property (frame_valid |=>
        frame_out[7:0] == $past(frame_in[7:0]))
        else $error("address echo wrong");
    AST_OLD: assert property (frame_valid &&
        frame_in[6:0] == regbank_pkg::A_MODE_SUPPLY |=>
        frame_out[15:8] == $past(ctrl_regs[0]))
        else $error("answer is not the old mode content");
    AST_MODE_WR: assert property (s_mode_wr ##0 frame_in[15:14] != 2'h3
        |=> op_mode == $past(frame_in[15:14]))
        else $error("mode field not written");
    AST_SOFT: assert property (s_mode_wr ##0 frame_in[15:14] == 2'h3
        |=> soft_reset_req)
        else $error("soft reset not requested");
    AST_SOFT_CLR: assert property (soft_reset_req |=>
        !soft_reset_req && op_mode == regbank_pkg::MODE_NORMAL)
        else $error("soft reset did not clear the bank");
    AST_RESTART: assert property (restart |=>
        op_mode == regbank_pkg::MODE_NORMAL)
        else $error("restart left mode not normal");
    AST_READ: assert property (s_take ##0 !frame_in[7] |=> $stable(op_mode))
        else $error("read frame changed the mode");
    AST_UNMAP: assert property (frame_valid && frame_in[6:0] == 7'h7f
        |=> frame_out[15:8] == 8'h00)
        else $error("unmapped address returned data");
endmodule

bind reg_bank reg_bank_sva u_reg_bank_sva (.clk(clk), .reset(reset),
    .frame_valid(frame_valid), .frame_in(frame_in), .restart(restart),
    .hw_mode_we(hw_mode_we), .frame_out(frame_out),
    .frame_out_valid(frame_out_valid), .op_mode(op_mode),
    .soft_reset_req(soft_reset_req), .ctrl_regs(ctrl_regs));

// [testbench/host_model.sv]
`timescale 1ns/1ps
// Serial master: sends one whole frame per bench request
module host_model (
    // Clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] go_frame,
    // Frame toward the bank
    output logic frame_valid,
    output logic [15:0] frame_in
);
    // Idle lines toggle each cycle between the last frame and its inverse so stale data cannot match
    // data byte high, mode bit 7
    always_ff @(posedge clk) begin
        frame_valid <= go;
        frame_in <= go ? go_frame : ~frame_in;
    end
endmodule

// [testbench/test_reg_bank.sv]
`timescale 1ns/1ps
module test_reg_bank;
    typedef struct packed {logic [15:0] f; logic [15:0] o;} row_t;
    logic clk = 1'b0, reset = 1'b1, go = 1'b0, restart = 1'b0;
    logic hw_mode_we = 1'b0, frame_valid, frame_out_valid, soft_reset_req;
    logic [15:0] go_frame = 16'h0000, frame_in, frame_out;
    logic [7:0] hw_mode_val = 8'h00;
    logic [7:0] flag_set [9];
    logic [7:0] ctrl_regs [16];
    logic [1:0] op_mode;
    int bad_count = 0, check_count = 0;
    // Frame then expected answer: old content in high byte, echo low
    // host keeps reserved bits zero on control writes except the all-ones write to A_BUS_ONE
    row_t rows [12] = '{
        '{16'hc485, 16'h0085}, '{16'h0005, 16'hc405},
        '{16'h4381, 16'h0081}, '{16'h8381, 16'h4381},
        '{16'h0381, 16'h8381}, '{16'h0001, 16'h0301},
        '{16'hab7f, 16'h007f}, '{16'hffff, 16'h00ff},
        '{16'hfffe, 16'h3cfe}, '{16'h007e, 16'h3c7e},
        '{16'hff83, 16'h0083}, '{16'h0003, 16'h0003}};

    always #2 clk = ~clk;

    host_model u_host_model (.clk(clk), .go(go), .go_frame(go_frame),
        .frame_valid(frame_valid), .frame_in(frame_in));
    reg_bank #(.ID_VALUE(8'h3c)) u_reg_bank (.clk(clk), .reset(reset),
        .frame_valid(frame_valid), .frame_in(frame_in), .restart(restart),
        .hw_mode_val(hw_mode_val), .hw_mode_we(hw_mode_we),
        .flag_set(flag_set), .frame_out(frame_out),
        .frame_out_valid(frame_out_valid), .op_mode(op_mode),
        .soft_reset_req(soft_reset_req), .ctrl_regs(ctrl_regs));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One frame, answer checked once it has landed
    task automatic send(input logic [15:0] f, input logic [15:0] o);
        @(posedge clk);
        go <= 1'b1;
        go_frame <= f;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1 cmp(frame_out, o);
    endtask

    task automatic final_report;
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the fifty or so cycles the tests use
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        foreach (flag_set[i]) flag_set[i] = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 cmp(frame_out, 16'h0000);
        cmp({13'h0, op_mode, frame_out_valid}, 16'h0000);
        // Table frames back to back; answers lag the request by two edges
        for (int i = 0; i < 14; i++) begin
            @(posedge clk);
            go <= (i < 12);
            go_frame <= rows[i % 12].f;
            if (i >= 2) #1 cmp(frame_out, rows[i - 2].o);
        end
        // Hardware update of modifiable mode bits
        @(posedge clk);
        hw_mode_val <= 8'h2c;
        hw_mode_we <= 1'b1;
        @(posedge clk);
        hw_mode_we <= 1'b0;
        send(16'h0001, 16'h2f01);
        // Restart keeps x bits, mode back to normal
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        send(16'h0001, 16'h2301);
        send(16'h0005, 16'hc405);
        // Flag set, then cleared by its own read
        @(posedge clk);
        flag_set[0] <= 8'h81;
        @(posedge clk);
        flag_set[0] <= 8'h00;
        send(16'h0040, 16'h8140);
        send(16'h0040, 16'h0040);
        send(16'hff40, 16'h0040);
        // Soft reset by mode code 11 clears the bank
        send(16'hc081, 16'h2381);
        repeat (2) @(posedge clk);
        send(16'h0005, 16'h0005);
        #1 cmp({14'h0, op_mode}, 16'h0000);
        final_report();
    end
endmodule
